//--- src/amp_fault_report_control.sv
// Fault report and protection control registers behind an AHB-Lite slave
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "amp_fault_consts.svh"

module amp_fault_report_control import amp_fault_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic overcurrent_live,
  input wire logic dc_error_live,
  input wire logic supply_high_live,
  input wire logic supply_low_live,
  input wire logic clock_error_live,
  input wire logic thermal_warning_live,
  input wire logic thermal_shutdown_live,
  input wire logic clock_detect_live,
  output logic fault_report_n,
  output logic outputs_hiz,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  localparam ctl_state_t ST_RESET = '{
    state: BUS_IDLE,
    hreadyout: 1'b1,
    pin_mask: `RST_PIN_MASK,
    latch_ctrl: `RST_LATCH_CTRL,
    misc_ctrl: `RST_MISC_CTRL,
    clear_rsvd: `RST_CLEAR_RSVD,
    fault_report_n: 1'b1,
    default: '0
  };

  ctl_state_t s_q;
  ctl_state_t s_d;
  logic [7:0] live;
  logic [7:0] rise;
  logic take;
  logic clear_pulse;

  // Word accesses only; anything else falls to the unmapped index
  function automatic logic [7:0] addr_index(input logic [31:0] a, input logic [2:0] sz);
    logic [7:0] r;
    r = `IDX_NONE;
    if (a[31:10] == 22'h000000 && a[1:0] == 2'b00 && sz == 3'b010) begin
      case (a[9:2])
        `IDX_WARN_STATUS, `IDX_PIN_MASK, `IDX_LATCH_CTRL, `IDX_MISC_CTRL,
        `IDX_CLEAR, `IDX_FAULT_STATUS, `IDX_IRQ_STATUS, `IDX_IRQ_ENABLE: r = a[9:2];
        default: r = `IDX_NONE;
      endcase
    end
    return r;
  endfunction

  // Sticky when held, otherwise the live level; a fresh edge beats a clear
  function automatic logic hold_or_live(input logic hold, input logic cur, input logic edge_in,
                                        input logic lvl, input logic clr);
    return hold ? (edge_in | (cur & ~clr)) : lvl;
  endfunction

  assign live = {clock_detect_live, thermal_shutdown_live, thermal_warning_live, clock_error_live,
                 supply_low_live, supply_high_live, dc_error_live, overcurrent_live};
  assign rise = live & ~s_q.prev_live;
  assign take = hsel && hready && htrans[1];

  assign clear_pulse = (s_q.state == BUS_WRITE) && (s_q.idx == `IDX_CLEAR) && hwdata[`BIT_CLEAR_CMD];

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [7:0] pin_vec;
    pin_vec = '0;
    s_d = s_q;
    s_d.prev_live = live;

    // Register writes land in the data phase; reads take one wait state so
    // a read right behind a write still sees the written value
    case (s_q.state)
      BUS_WRITE: begin
        case (s_q.idx)
          `IDX_PIN_MASK: s_d.pin_mask = hwdata[7:0];
          `IDX_LATCH_CTRL: s_d.latch_ctrl = hwdata[7:0];
          `IDX_MISC_CTRL: s_d.misc_ctrl = hwdata[7:0];
          `IDX_CLEAR: s_d.clear_rsvd = hwdata[6:0];
          `IDX_IRQ_ENABLE: s_d.irq_enable = hwdata[7:0];
          default: ;
        endcase
      end
      BUS_RD_WAIT: begin
        s_d.hrdata = 32'h00000000;
        case (s_q.idx)
          `IDX_WARN_STATUS: s_d.hrdata[`BIT_WARN_FLAG] = s_q.fault_st[`EV_TW];
          `IDX_PIN_MASK: s_d.hrdata[7:0] = s_q.pin_mask;
          `IDX_LATCH_CTRL: s_d.hrdata[7:0] = s_q.latch_ctrl;
          `IDX_MISC_CTRL: s_d.hrdata[7:0] = s_q.misc_ctrl;
          `IDX_CLEAR: s_d.hrdata[6:0] = s_q.clear_rsvd;
          `IDX_FAULT_STATUS: begin
            s_d.hrdata[`BIT_HIDE_OC] = s_q.fault_st[`EV_OC];
            s_d.hrdata[`BIT_HIDE_DC] = s_q.fault_st[`EV_DC];
            s_d.hrdata[`BIT_HIDE_HIGH] = s_q.fault_st[`EV_HIGH];
            s_d.hrdata[`BIT_HIDE_LOW] = s_q.fault_st[`EV_LOW];
            s_d.hrdata[`BIT_HIDE_CLK] = s_q.fault_st[`EV_CLK];
            s_d.hrdata[`BIT_HIZ_STATUS] = s_q.outputs_hiz;
            s_d.hrdata[`BIT_DET_STATUS] = s_q.fault_st[`EV_DET];
            s_d.hrdata[`BIT_HIDE_TSD] = s_q.fault_st[`EV_TSD];
          end
          `IDX_IRQ_STATUS: s_d.hrdata[7:0] = s_q.irq_status;
          `IDX_IRQ_ENABLE: s_d.hrdata[7:0] = s_q.irq_enable;
          default: ;
        endcase
        s_d.hreadyout = 1'b1;
        s_d.state = BUS_RD_DONE;
      end
      default: ;
    endcase

    if (s_q.state != BUS_RD_WAIT) begin
      if (take) begin
        s_d.idx = addr_index(haddr, hsize);
        s_d.state = hwrite ? BUS_WRITE : BUS_RD_WAIT;
        s_d.hreadyout = hwrite;
      end else begin
        s_d.state = BUS_IDLE;
        s_d.hreadyout = 1'b1;
      end
    end

    // analog faults: sticky, cleared by command, fresh edge wins
    s_d.fault_st[`EV_OC] = rise[`EV_OC] | (s_q.fault_st[`EV_OC] & ~clear_pulse);
    s_d.fault_st[`EV_DC] = rise[`EV_DC] | (s_q.fault_st[`EV_DC] & ~clear_pulse);
    s_d.fault_st[`EV_HIGH] = rise[`EV_HIGH] | (s_q.fault_st[`EV_HIGH] & ~clear_pulse);
    s_d.fault_st[`EV_LOW] = rise[`EV_LOW] | (s_q.fault_st[`EV_LOW] & ~clear_pulse);
    s_d.fault_st[`EV_CLK] = hold_or_live(s_q.latch_ctrl[`BIT_CLK_HOLD], s_q.fault_st[`EV_CLK],
                                         rise[`EV_CLK], live[`EV_CLK], clear_pulse);
    s_d.fault_st[`EV_TW] = hold_or_live(s_q.latch_ctrl[`BIT_TW_HOLD], s_q.fault_st[`EV_TW],
                                        rise[`EV_TW], live[`EV_TW], clear_pulse);
    // thermal shutdown hold, re-armed only by a new rising edge
    s_d.fault_st[`EV_TSD] = hold_or_live(s_q.latch_ctrl[`BIT_TSD_HOLD], s_q.fault_st[`EV_TSD],
                                         rise[`EV_TSD], live[`EV_TSD], clear_pulse);
    // clock detect status held or tracking
    s_d.fault_st[`EV_DET] = s_q.misc_ctrl[`BIT_DET_HOLD] ?
                            (live[`EV_DET] | (s_q.fault_st[`EV_DET] & ~clear_pulse)) : live[`EV_DET];

    // shutdown stays until cleared, or until cool when self recovery is on
    if (rise[`EV_TSD]) begin
      s_d.tsd_stop = 1'b1;
    end else if (clear_pulse || (s_q.misc_ctrl[`BIT_SELF_REC] && !live[`EV_TSD])) begin
      s_d.tsd_stop = 1'b0;
    end
    // supply faults recover on their own; thermal follows the stop state
    s_d.outputs_hiz = live[`EV_HIGH] | live[`EV_LOW] | s_d.tsd_stop;

    // masks only gate the pin, never the status
    pin_vec[`BIT_HIDE_OC] = s_d.fault_st[`EV_OC];
    pin_vec[`BIT_HIDE_DC] = s_d.fault_st[`EV_DC];
    pin_vec[`BIT_HIDE_HIGH] = s_d.fault_st[`EV_HIGH];
    pin_vec[`BIT_HIDE_LOW] = s_d.fault_st[`EV_LOW];
    pin_vec[`BIT_HIDE_CLK] = s_d.fault_st[`EV_CLK];
    pin_vec[`BIT_HIDE_TSD] = s_d.fault_st[`EV_TSD];
    // pin masking, warning hidden separately
    // New masks count at the landing edge, so a masked fault never blips the pin
    s_d.fault_report_n = ~((|(pin_vec & ~s_d.pin_mask)) |
                           (s_d.fault_st[`EV_TW] & ~s_d.latch_ctrl[`BIT_HIDE_TW]));

    // Interrupt status: write one clears, a new event in the same cycle wins
    if (s_q.state == BUS_WRITE && s_q.idx == `IDX_IRQ_STATUS) begin
      s_d.irq_status = rise | (s_q.irq_status & ~hwdata[7:0]);
    end else begin
      s_d.irq_status = rise | s_q.irq_status;
    end
    s_d.irq = |(s_d.irq_status & s_d.irq_enable);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= ST_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata = s_q.hrdata;
  assign hreadyout = s_q.hreadyout;
  assign hresp = 1'b0;
  assign fault_report_n = s_q.fault_report_n;
  assign outputs_hiz = s_q.outputs_hiz;
  assign irq = s_q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic [7:0] pin_q;
  assign pin_q = {s_q.fault_st[`EV_TSD], 2'b00, s_q.fault_st[`EV_CLK], s_q.fault_st[`EV_LOW],
                  s_q.fault_st[`EV_HIGH], s_q.fault_st[`EV_DC], s_q.fault_st[`EV_OC]};

  logic tw_quiet;
  assign tw_quiet = !s_q.fault_st[`EV_TW] || s_q.latch_ctrl[`BIT_HIDE_TW];

  warn_read_zero_a: assert property (
    (s_q.state == BUS_RD_DONE && s_q.idx == `IDX_WARN_STATUS) |->
      (hrdata[31:4] == 28'h0000000 && hrdata[2:0] == 3'h0 && hrdata[3] == $past(s_q.fault_st[`EV_TW])))
    else $error("warning status read shows stray bits");

  tsd_pin_hidden_a: assert property (
    (s_q.pin_mask[`BIT_HIDE_TSD] && pin_q[`BIT_HIDE_TSD] && (pin_q[6:0] & ~s_q.pin_mask[6:0]) == 7'h00
     && tw_quiet) |-> fault_report_n)
    else $error("masked thermal shutdown reached the pin");

  clk_pin_hidden_a: assert property (
    (s_q.pin_mask[`BIT_HIDE_CLK] && pin_q[`BIT_HIDE_CLK] && (pin_q & ~s_q.pin_mask) == 8'h00
     && tw_quiet) |-> fault_report_n)
    else $error("masked clock fault reached the pin");

  low_pin_shown_a: assert property (
    (!s_q.pin_mask[`BIT_HIDE_LOW] && pin_q[`BIT_HIDE_LOW]) |-> !fault_report_n)
    else $error("unmasked supply low fault missing on the pin");

  oc_pin_hidden_a: assert property (
    (s_q.pin_mask == 8'h01 && pin_q == 8'h01 && tw_quiet) |-> fault_report_n)
    else $error("masked overcurrent reached the pin");

  status_despite_mask_a: assert property (
    (overcurrent_live && !s_q.prev_live[`EV_OC] && s_q.pin_mask[`BIT_HIDE_OC]) |=> s_q.fault_st[`EV_OC])
    else $error("masked overcurrent did not set its status");

  clock_hold_a: assert property (
    (s_q.latch_ctrl[`BIT_CLK_HOLD] && s_q.fault_st[`EV_CLK] && !clear_pulse) |=> s_q.fault_st[`EV_CLK])
    else $error("held clock fault dropped without a clear");

  sequence hot_clear_s;
    clear_pulse && thermal_shutdown_live && s_q.prev_live[`EV_TSD] && s_q.latch_ctrl[`BIT_TSD_HOLD];
  endsequence
  sequence still_hot_s;
    thermal_shutdown_live [*2];
  endsequence
  tsd_clear_stays_a: assert property (
    hot_clear_s ##1 still_hot_s |-> !s_q.fault_st[`EV_TSD])
    else $error("thermal shutdown status returned without a fresh trigger");

  sequence cooled_s;
    s_q.tsd_stop && s_q.misc_ctrl[`BIT_SELF_REC] && !thermal_shutdown_live;
  endsequence
  sequence supply_ok_s;
    !supply_high_live && !supply_low_live;
  endsequence
  self_recover_a: assert property (
    cooled_s ##0 supply_ok_s |=> !outputs_hiz)
    else $error("outputs stayed off after cooling with self recovery");

  no_recover_a: assert property (
    (s_q.tsd_stop && !s_q.misc_ctrl[`BIT_SELF_REC] && !clear_pulse) |=> outputs_hiz)
    else $error("outputs resumed without self recovery or clear");

  supply_hiz_a: assert property (
    $rose(supply_high_live) |=> outputs_hiz ##0 s_q.fault_st[`EV_HIGH])
    else $error("supply high fault did not stop outputs and set status");

  clear_wipes_a: assert property (
    (clear_pulse && (rise[3:0] == 4'h0)) |=> (s_q.fault_st[3:0] == 4'h0))
    else $error("clear command left an analog fault set");

  irq_level_a: assert property (
    (irq == |(s_q.irq_status & s_q.irq_enable)))
    else $error("interrupt output disagrees with status and enable");

  read_wait_a: assert property (
    (take && !hwrite && s_q.state != BUS_RD_WAIT) |=> !hreadyout ##1 hreadyout)
    else $error("read did not take exactly one wait state");

endmodule
`default_nettype wire

//--- src/amp_fault_consts.svh
// Offsets, field positions, reset values and limits of the fault report registers
// Behaviour
// - Thermal warning flag at bit 3, rest zero
// - Mask bit 7 hides thermal shutdown on pin
// - Mask bit 4 hides clock fault on pin
// - Mask bit 3 hides supply low on pin
// - Mask bit 2 hides supply high on pin
// - Mask bit 1 hides DC error on pin
// - Mask bit 0 hides overcurrent; masks reset zero
// - Latch bit 5 holds clock fault
// - Latch bit 4 holds thermal shutdown fault
// - Latch bit 3 holds thermal warning
// - Latch bit 2 hides thermal warning report
// - Misc bit 7 holds or tracks clock detect
// - Misc bit 4 enables thermal shutdown self recovery
// - Writing one to clear bit 7 clears faults
// - Supply/thermal fault: outputs off, status, pin report
// - Cleared thermal status waits for fresh trigger
`ifndef AMP_FAULT_CONSTS_SVH
`define AMP_FAULT_CONSTS_SVH

// Register indices; byte address is four times the index
`define IDX_WARN_STATUS 8'h73
`define IDX_PIN_MASK 8'h74
`define IDX_LATCH_CTRL 8'h75
`define IDX_MISC_CTRL 8'h76
`define IDX_CLEAR 8'h78
`define IDX_FAULT_STATUS 8'h79
`define IDX_IRQ_STATUS 8'h7A
`define IDX_IRQ_ENABLE 8'h7B
`define IDX_NONE 8'hFF

// Reset values
`define RST_PIN_MASK 8'h00
`define RST_LATCH_CTRL 8'hF8
`define RST_MISC_CTRL 8'h00
`define RST_CLEAR_RSVD 7'h00

// Field positions
`define BIT_WARN_FLAG 3
`define BIT_HIDE_TSD 7
`define BIT_HIDE_CLK 4
`define BIT_HIDE_LOW 3
`define BIT_HIDE_HIGH 2
`define BIT_HIDE_DC 1
`define BIT_HIDE_OC 0
`define BIT_CLK_HOLD 5
`define BIT_TSD_HOLD 4
`define BIT_TW_HOLD 3
`define BIT_HIDE_TW 2
`define BIT_DET_HOLD 7
`define BIT_SELF_REC 4
`define BIT_CLEAR_CMD 7
`define BIT_DET_STATUS 6
`define BIT_HIZ_STATUS 5

// Event vector positions, also the interrupt status layout
`define EV_OC 0
`define EV_DC 1
`define EV_HIGH 2
`define EV_LOW 3
`define EV_CLK 4
`define EV_TW 5
`define EV_TSD 6
`define EV_DET 7

// Thermal warning trip point, degrees Celsius, set by the analog sensor
`define THERMAL_WARN_CELSIUS 135

`endif

//--- src/amp_fault_pkg.sv
// Types of the amplifier fault report block
package amp_fault_pkg;

  typedef enum logic [3:0] {
    BUS_IDLE    = 4'b0001,
    BUS_WRITE   = 4'b0010,
    BUS_RD_WAIT = 4'b0100,
    BUS_RD_DONE = 4'b1000
  } bus_state_t;

  typedef struct packed {
    bus_state_t state;
    logic [7:0] idx;
    logic hreadyout;
    logic [31:0] hrdata;
    logic [7:0] pin_mask;
    logic [7:0] latch_ctrl;
    logic [7:0] misc_ctrl;
    logic [6:0] clear_rsvd;
    logic [7:0] fault_st;
    logic tsd_stop;
    logic [7:0] prev_live;
    logic [7:0] irq_status;
    logic [7:0] irq_enable;
    logic irq;
    logic fault_report_n;
    logic outputs_hiz;
  } ctl_state_t;

endpackage

//--- bench/tb.sv
// Self-checking bench for the fault report register block
`timescale 1ns/1ps
`default_nettype none
`include "amp_fault_consts.svh"

module tb;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic fault_report_n, outputs_hiz, irq;
  logic [7:0] live;
  int miscompares, comparisons, seed;
  int shadow [int];
  logic [7:0] rw_idx [4] = '{`IDX_PIN_MASK, `IDX_LATCH_CTRL, `IDX_MISC_CTRL, `IDX_CLEAR};
  int ev [6] = '{0, 1, 2, 3, 4, 6};
  int mb [6] = '{0, 1, 2, 3, 4, 7};

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  amp_fault_report_control u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .overcurrent_live(live[0]),
    .dc_error_live(live[1]), .supply_high_live(live[2]), .supply_low_live(live[3]),
    .clock_error_live(live[4]), .thermal_warning_live(live[5]), .thermal_shutdown_live(live[6]),
    .clock_detect_live(live[7]), .fault_report_n(fault_report_n), .outputs_hiz(outputs_hiz),
    .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    chk_reg({31'h0, got}, {31'h0, exp});
  endtask

  // Ready and read data are taken at the rising edge, before the slave updates them
  task automatic wait_ready();
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                      input logic [2:0] sz);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= sz;
    haddr <= {22'h0, idx, 2'b00};
    wait_ready();
    htrans <= 2'b00;
    if (wr) hwdata <= wd;
    if (wr && sz == 3'b010 && shadow.exists(idx)) shadow[idx] = wd & (idx == `IDX_CLEAR ? 32'h7F : 32'hFF);
    wait_ready();
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    xfer(1'b1, idx, d, 3'b010);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0, 3'b010);
    chk_reg(rd, exp);
    chk_pin(hresp, 1'b0);
  endtask

  function automatic logic [31:0] model_rd(input logic [7:0] idx);
    return shadow.exists(idx) ? shadow[idx] : 32'h0;
  endfunction

  // Live faults change after an edge; outputs checked a cycle and a half later
  task automatic drive_live(input logic [7:0] v);
    @(posedge hclk);
    live <= v;
    repeat (2) @(negedge hclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  initial begin
    #(100 * 8000);
    miscompares++;
    summarize();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    live = 8'h00;
    seed = 95;
    shadow[`IDX_PIN_MASK] = 32'h00;
    shadow[`IDX_LATCH_CTRL] = 32'hF8;
    shadow[`IDX_MISC_CTRL] = 32'h00;
    shadow[`IDX_CLEAR] = 32'h00;
    shadow[`IDX_IRQ_ENABLE] = 32'h00;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(`IDX_WARN_STATUS, 32'h00);
    for (int k = 0; k < 4; k++) rd_chk(rw_idx[k], model_rd(rw_idx[k]));
    for (int i = 0; i < 12; i++) begin
      wr(rw_idx[i % 4], $random(seed));
      rd_chk(rw_idx[i % 4], model_rd(rw_idx[i % 4]));
    end
    // Read-only, wrong size and unmapped places must not take writes
    wr(`IDX_WARN_STATUS, 32'hFF);
    rd_chk(`IDX_WARN_STATUS, 32'h00);
    xfer(1'b1, `IDX_PIN_MASK, 32'hA5, 3'b000);
    rd_chk(`IDX_PIN_MASK, model_rd(`IDX_PIN_MASK));
    wr(`IDX_NONE, 32'h5A);
    rd_chk(`IDX_NONE, 32'h0);
    wr(`IDX_LATCH_CTRL, 32'hF8);
    wr(`IDX_MISC_CTRL, 32'h00);
    wr(`IDX_IRQ_ENABLE, 32'hFF);
    // Each masked fault: pin quiet, status and interrupt still raised
    for (int i = 0; i < 6; i++) begin
      wr(`IDX_PIN_MASK, 32'h1 << mb[i]);
      drive_live(8'h1 << ev[i]);
      chk_pin(fault_report_n, 1'b1);
      chk_pin(outputs_hiz, ev[i] inside {2, 3, 6});
      chk_pin(irq, 1'b1);
      rd_chk(`IDX_FAULT_STATUS, (32'h1 << mb[i]) | (ev[i] inside {2, 3, 6} ? 32'h20 : 32'h0));
      rd_chk(`IDX_IRQ_STATUS, 32'h1 << ev[i]);
      wr(`IDX_PIN_MASK, 32'h00);
      @(negedge hclk);
      chk_pin(fault_report_n, 1'b0);
      drive_live(8'h00);
      chk_pin(outputs_hiz, ev[i] == 6);
      wr(`IDX_CLEAR, 32'h80);
      rd_chk(`IDX_FAULT_STATUS, 32'h0);
      wr(`IDX_IRQ_STATUS, 32'hFF);
      @(negedge hclk);
      chk_pin(fault_report_n, 1'b1);
      chk_pin(irq, 1'b0);
    end
    // Held warning, then hidden from the pin
    drive_live(8'h20);
    drive_live(8'h00);
    rd_chk(`IDX_WARN_STATUS, 32'h08);
    @(negedge hclk);
    chk_pin(fault_report_n, 1'b0);
    wr(`IDX_LATCH_CTRL, 32'hFC);
    @(negedge hclk);
    chk_pin(fault_report_n, 1'b1);
    wr(`IDX_CLEAR, 32'h80);
    rd_chk(`IDX_WARN_STATUS, 32'h00);
    // Hold bits off: clock and warning follow live; interrupt masked
    wr(`IDX_IRQ_ENABLE, 32'h00);
    wr(`IDX_LATCH_CTRL, 32'hD0);
    drive_live(8'h30);
    chk_pin(irq, 1'b0);
    rd_chk(`IDX_WARN_STATUS, 32'h08);
    rd_chk(`IDX_FAULT_STATUS, 32'h10);
    drive_live(8'h00);
    rd_chk(`IDX_FAULT_STATUS, 32'h00);
    rd_chk(`IDX_WARN_STATUS, 32'h00);
    rd_chk(`IDX_IRQ_STATUS, 32'h30);
    wr(`IDX_IRQ_ENABLE, 32'h10);
    @(negedge hclk);
    chk_pin(irq, 1'b1);
    wr(`IDX_IRQ_STATUS, 32'h10);
    @(negedge hclk);
    chk_pin(irq, 1'b0);
    // Clock detect tracks, then holds
    wr(`IDX_LATCH_CTRL, 32'hF8);
    drive_live(8'h80);
    rd_chk(`IDX_FAULT_STATUS, 32'h40);
    drive_live(8'h00);
    rd_chk(`IDX_FAULT_STATUS, 32'h00);
    wr(`IDX_MISC_CTRL, 32'h80);
    drive_live(8'h80);
    drive_live(8'h00);
    rd_chk(`IDX_FAULT_STATUS, 32'h40);
    wr(`IDX_CLEAR, 32'h80);
    rd_chk(`IDX_FAULT_STATUS, 32'h00);
    // Cleared shutdown stays clear while hot, returns on a fresh trigger
    wr(`IDX_MISC_CTRL, 32'h00);
    drive_live(8'h40);
    wr(`IDX_CLEAR, 32'h80);
    rd_chk(`IDX_FAULT_STATUS, 32'h00);
    drive_live(8'h00);
    drive_live(8'h40);
    rd_chk(`IDX_FAULT_STATUS, 32'hA0);
    wr(`IDX_CLEAR, 32'h80);
    wr(`IDX_MISC_CTRL, 32'h10);
    drive_live(8'h00);
    drive_live(8'h40);
    chk_pin(outputs_hiz, 1'b1);
    drive_live(8'h00);
    repeat (2) @(negedge hclk);
    chk_pin(outputs_hiz, 1'b0);
    // Mid-run reset drops the held shutdown and restores the misc, latch and interrupt enable registers
    chk_pin(fault_report_n, 1'b0);
    @(posedge hclk);
    hresetn <= 1'b0;
    @(negedge hclk);
    chk_pin(fault_report_n, 1'b1);
    chk_pin(irq, 1'b0);
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(`IDX_MISC_CTRL, 32'h00);
    rd_chk(`IDX_LATCH_CTRL, 32'hF8);
    rd_chk(`IDX_FAULT_STATUS, 32'h00);
    rd_chk(`IDX_IRQ_ENABLE, 32'h00);
    summarize();
  end
endmodule
`default_nettype wire
